// ==== rxq_pkg.sv ====
`default_nettype none
package rxq_pkg;
  // Device register offsets.
  localparam logic [7:0] RECEIVE_CONTROL_ONE_OFS       = 8'h74;
  localparam logic [7:0] RECEIVE_CONTROL_TWO_OFS       = 8'h76;
  localparam logic [7:0] HEAD_FRAME_STATUS_OFS         = 8'h7c;
  localparam logic [7:0] HEAD_FRAME_BYTE_COUNT_OFS     = 8'h7e;
  localparam logic [7:0] QUEUE_CONTROL_OFS             = 8'h82;
  localparam logic [7:0] RECEIVE_DATA_POINTER_OFS      = 8'h86;
  localparam logic [7:0] DURATION_TIMER_THRESHOLD_OFS  = 8'h8c;
  localparam logic [7:0] BYTE_COUNT_THRESHOLD_OFS      = 8'h8e;
  localparam logic [7:0] INTERRUPT_ENABLE_OFS          = 8'h90;
  localparam logic [7:0] INTERRUPT_STATUS_OFS          = 8'h92;
  localparam logic [7:0] FRAME_COUNT_AND_THRESHOLD_OFS = 8'h9c;
  localparam logic [7:0] DATA_PORT_OFS                 = 8'hc0;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Field positions.
  localparam int RC1_BLOCK_BIT   = 0;
  localparam int RC1_FLOW_BIT    = 10;
  localparam int QC_SESSION_BIT  = 3;
  localparam int QC_AUTO_DQ_BIT  = 4;
  localparam int QC_FC_EN_BIT    = 5;
  localparam int QC_BC_EN_BIT    = 6;
  localparam int QC_TM_EN_BIT    = 7;
  localparam int QC_IP_OFS_BIT   = 9;
  localparam int QC_STAT_LSB     = 10;
  localparam int DP_AUTO_INC_BIT = 14;
  localparam int IRQ_RX_BIT      = 13;
  localparam logic [15:0] QC_WMASK = 16'h02f8;

  // Queue sizing.
  localparam int unsigned MEM_WORDS       = 6144;
  localparam int unsigned SLOTS           = 32;
  localparam int unsigned FRAME_MAX_BYTES = 2000;
  localparam int unsigned IP_OFS_BYTES    = 2;
  localparam int unsigned FRAME_WORDS_MAX = 2 + (FRAME_MAX_BYTES + IP_OFS_BYTES + 1) / 2;
  localparam int unsigned PAUSE_WORDS     = MEM_WORDS - 2 * FRAME_WORDS_MAX;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;

  // Bridge register offsets on the AXI4-Lite side.
  localparam logic [3:0] BR_CMD_OFS    = 4'h0;
  localparam logic [3:0] BR_STATUS_OFS = 4'h4;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [3:0] {
    W_IDLE = 4'b0001,
    W_DATA = 4'b0010,
    W_STAT = 4'b0100,
    W_CNT  = 4'b1000
  } wr_state_t;

  function automatic logic [12:0] wadd(input logic [12:0] a, input logic [12:0] n);
    logic [13:0] s;
    s = {1'b0, a} + {1'b0, n};
    if (s >= 14'(MEM_WORDS)) s = s - 14'(MEM_WORDS);
    return s[12:0];
  endfunction
endpackage
`default_nettype wire

// ==== rxq_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface rxq_if (
  input wire logic aclk
);
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  logic        irq;

  modport dev (input req, input we, input addr, input wdata, output ack, output rdata, output irq);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata, input irq);
endinterface // rxq_if
`default_nettype wire

// ==== rxq_device.sv ====
// Function
// [RQ1] Frame stored as status, count, then data
// [RQ2] Store up to 2000 bytes per frame
// [RQ3] Control one bit10 flow, bit0 block
// [RQ4] Software-selected checksum checks for four protocols
// [RQ5] Head status register shows head frame status
// [RQ6] Head count register low twelve bits
// [RQ7] Queue control bit3 opens data-port session
// [RQ8] Queue control bit4 enables automatic dequeue
// [RQ9] Bit9 inserts two-byte offset before frame
// [RQ10] Pointer bit14 auto-increments read address
// [RQ11] Residence timer over threshold raises interrupt
// [RQ12] Queued bytes over threshold raise interrupt
// [RQ13] Queued frames over threshold raise interrupt
// [RQ14] Frame-count upper byte snapshots frames at interrupt
// [RQ15] Enable bit13 gates receive interrupt
// [RQ16] Status bits clear on write one
// [RQ17] First session read is dummy, discarded
// [RQ18] Host reads frame up to double word
// [RQ19] Clearing interrupt refreshes frame-count register
// [RQ20] Frame-count read loads head header registers
// [RQ21] Both header reads advance to next frame
// [RQ22] Auto dequeue releases space after reading
`timescale 1ns/10ps
`default_nettype none
module rxq_device (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  rxq_if.dev               bus,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic [15:0] rx_status,
  output logic             rx_ready,
  output logic             rx_pause,
  output logic [3:0]       csum_en
);
  logic [15:0] mem_q [rxq_pkg::MEM_WORDS];
  logic [15:0] dstat_q [rxq_pkg::SLOTS];
  logic [11:0] dcnt_q [rxq_pkg::SLOTS];
  logic [12:0] dbase_q [rxq_pkg::SLOTS];

  rxq_pkg::wr_state_t ws_q;
  logic [15:0] rc1_q, rc2_q, qc_q, dp_q, dttr_q, dbct_q, ier_q, hstat_q, rdata_q;
  logic [11:0] hbc_q, bc_q, lim_q;
  logic [7:0]  fct_q, snap_q, lo_q, tick_q;
  logic [12:0] wptr_q, base_q, cur_q, used_q, mem_wa, hd_wa;
  logic [15:0] stat_q, bytes_q, tmr_q, isr_q, mem_wd, rdata_d;
  logic [4:0]  wi_q, hs_q, hr_q;
  logic [5:0]  frames_q;
  logic [2:0]  ov_q;
  logic        half_q, ack_q, irq_q, first_q, seen_s_q, seen_b_q, rx_ready_q, pause_q;
  logic [3:0]  csum_q;
  logic        mem_we, take, rd, wr, start, enq, deq, rx_take, keep, set_irq, clr_irq;
  logic [12:0] enq_words, deq_words;

  assign take    = bus.req && !ack_q;
  assign rd      = take && !bus.we;
  assign wr      = take && bus.we;
  assign start   = ws_q == rxq_pkg::W_IDLE && rx_valid && rc1_q[rxq_pkg::RC1_BLOCK_BIT]
                   && used_q <= 13'(rxq_pkg::MEM_WORDS - rxq_pkg::FRAME_WORDS_MAX)
                   && frames_q < 6'(rxq_pkg::SLOTS);
  assign rx_take = ws_q == rxq_pkg::W_DATA && rx_valid && rx_ready_q;
  // [RQ2] Size cap.
  assign keep    = bc_q < lim_q;
  assign enq     = ws_q == rxq_pkg::W_CNT;
  // [RQ8] Auto dequeue trigger.
  assign deq     = wr && bus.addr == rxq_pkg::QUEUE_CONTROL_OFS && !bus.wdata[rxq_pkg::QC_SESSION_BIT]
                   && qc_q[rxq_pkg::QC_SESSION_BIT] && qc_q[rxq_pkg::QC_AUTO_DQ_BIT] && frames_q != 6'h00;
  assign enq_words = 13'd2 + 13'((bc_q + 12'h001) >> 1);
  assign deq_words = 13'd2 + 13'((dcnt_q[hs_q] + 12'h001) >> 1);
  assign hd_wa     = rxq_pkg::wadd(dbase_q[hs_q], {3'h0, dp_q[10:1]});
  assign clr_irq   = wr && bus.addr == rxq_pkg::INTERRUPT_STATUS_OFS && bus.wdata[rxq_pkg::IRQ_RX_BIT];
  assign set_irq   = |ov_q;

  // [RQ1] Memory layout write mux.
  always_comb begin
    mem_we = 1'b0;
    mem_wa = cur_q;
    mem_wd = {8'h00, rx_data};
    if (start && qc_q[rxq_pkg::QC_IP_OFS_BIT]) begin
      mem_we = 1'b1;
      mem_wa = rxq_pkg::wadd(wptr_q, 13'd2);
      mem_wd = 16'h0000;
    end else if (rx_take && keep && (half_q || rx_last)) begin
      mem_we = 1'b1;
      mem_wd = half_q ? {rx_data, lo_q} : {8'h00, rx_data};
    end else if (ws_q == rxq_pkg::W_STAT) begin
      mem_we = 1'b1;
      mem_wa = base_q;
      mem_wd = stat_q;
    end else if (enq) begin
      mem_we = 1'b1;
      mem_wa = rxq_pkg::wadd(base_q, 13'd1);
      mem_wd = {4'h0, bc_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (mem_we) mem_q[mem_wa] <= mem_wd;
    if (enq) begin
      dstat_q[wi_q] <= stat_q;
      dcnt_q[wi_q]  <= bc_q;
      dbase_q[wi_q] <= base_q;
    end
  end

  // Line-side filling of the queue; one frame in flight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_q <= rxq_pkg::W_IDLE;
      rx_ready_q <= 1'b0;
      wptr_q <= 13'h0000; base_q <= 13'h0000; cur_q <= 13'h0000;
      bc_q <= 12'h000; lim_q <= 12'h000; half_q <= 1'b0; lo_q <= 8'h00;
      stat_q <= 16'h0000; wi_q <= 5'h00;
    end else begin
      unique case (ws_q)
        rxq_pkg::W_IDLE: if (start) begin
          base_q <= wptr_q;
          half_q <= 1'b0;
          rx_ready_q <= 1'b1;
          ws_q <= rxq_pkg::W_DATA;
          // [RQ9] Two-byte offset.
          if (qc_q[rxq_pkg::QC_IP_OFS_BIT]) begin
            cur_q <= rxq_pkg::wadd(wptr_q, 13'd3);
            bc_q  <= 12'(rxq_pkg::IP_OFS_BYTES);
            lim_q <= 12'(rxq_pkg::FRAME_MAX_BYTES + rxq_pkg::IP_OFS_BYTES);
          end else begin
            cur_q <= rxq_pkg::wadd(wptr_q, 13'd2);
            bc_q  <= 12'h000;
            lim_q <= 12'(rxq_pkg::FRAME_MAX_BYTES);
          end
        end
        rxq_pkg::W_DATA: if (rx_take) begin
          if (keep) begin
            bc_q <= bc_q + 12'h001;
            half_q <= ~half_q;
            lo_q <= rx_data;
            if (half_q) cur_q <= rxq_pkg::wadd(cur_q, 13'd1);
          end
          if (rx_last) begin
            stat_q <= rx_status;
            rx_ready_q <= 1'b0;
            ws_q <= rxq_pkg::W_STAT;
          end
        end
        rxq_pkg::W_STAT: ws_q <= rxq_pkg::W_CNT;
        rxq_pkg::W_CNT: begin
          wptr_q <= rxq_pkg::wadd(base_q, enq_words);
          wi_q <= wi_q + 5'h01;
          ws_q <= rxq_pkg::W_IDLE;
        end
      endcase
    end
  end

  // [RQ22] Space accounting and release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames_q <= 6'h00; used_q <= 13'h0000; bytes_q <= 16'h0000; hs_q <= 5'h00;
    end else begin
      frames_q <= frames_q + (enq ? 6'h01 : 6'h00) - (deq ? 6'h01 : 6'h00);
      used_q   <= used_q + (enq ? enq_words : 13'h0000) - (deq ? deq_words : 13'h0000);
      bytes_q  <= bytes_q + (enq ? {4'h0, bc_q} : 16'h0000) - (deq ? {4'h0, dcnt_q[hs_q]} : 16'h0000);
      if (deq) hs_q <= hs_q + 5'h01;
    end
  end

  // [RQ11] Residence time in microsecond steps.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 8'h00; tmr_q <= 16'h0000;
    end else begin
      tick_q <= (tick_q == 8'(rxq_pkg::TICK_CYCLES - 1)) ? 8'h00 : tick_q + 8'h01;
      if (frames_q == 6'h00 || deq) tmr_q <= 16'h0000;
      else if (tick_q == 8'(rxq_pkg::TICK_CYCLES - 1) && tmr_q != 16'hffff) tmr_q <= tmr_q + 16'h0001;
    end
  end

  // Threshold status, the sticky receive flag and its gated output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_q <= 3'h0; isr_q <= rxq_pkg::REG_RESET; snap_q <= 8'h00; irq_q <= 1'b0;
    end else begin
      // [RQ13] Frame threshold.
      ov_q[0] <= qc_q[rxq_pkg::QC_FC_EN_BIT] && frames_q > fct_q[5:0] && fct_q[7:6] == 2'h0;
      // [RQ12] Byte threshold.
      ov_q[1] <= qc_q[rxq_pkg::QC_BC_EN_BIT] && bytes_q > dbct_q;
      // [RQ11] Timer threshold.
      ov_q[2] <= qc_q[rxq_pkg::QC_TM_EN_BIT] && tmr_q > dttr_q;
      // [RQ16] Set wins over write-one clear.
      isr_q[rxq_pkg::IRQ_RX_BIT] <= set_irq || (isr_q[rxq_pkg::IRQ_RX_BIT] && !clr_irq);
      // [RQ14] [RQ19] Frame snapshot.
      if ((set_irq && !isr_q[rxq_pkg::IRQ_RX_BIT]) || clr_irq) snap_q <= {2'h0, frames_q};
      // [RQ15] Enable gate.
      irq_q <= isr_q[rxq_pkg::IRQ_RX_BIT] && ier_q[rxq_pkg::IRQ_RX_BIT];
    end
  end

  // Software-written control and the header walk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc1_q <= rxq_pkg::REG_RESET; rc2_q <= rxq_pkg::REG_RESET; qc_q <= rxq_pkg::REG_RESET;
      dp_q <= rxq_pkg::REG_RESET; dttr_q <= rxq_pkg::REG_RESET; dbct_q <= rxq_pkg::REG_RESET;
      ier_q <= rxq_pkg::REG_RESET; fct_q <= 8'h00; first_q <= 1'b0;
      hstat_q <= 16'h0000; hbc_q <= 12'h000; hr_q <= 5'h00; seen_s_q <= 1'b0; seen_b_q <= 1'b0;
    end else begin
      if (wr) begin
        unique case (bus.addr)
          rxq_pkg::RECEIVE_CONTROL_ONE_OFS: rc1_q <= bus.wdata;
          rxq_pkg::RECEIVE_CONTROL_TWO_OFS: rc2_q <= bus.wdata;
          rxq_pkg::QUEUE_CONTROL_OFS: begin
            qc_q <= bus.wdata & rxq_pkg::QC_WMASK;
            // [RQ7] [RQ17] Session start arms the dummy read.
            if (bus.wdata[rxq_pkg::QC_SESSION_BIT] && !qc_q[rxq_pkg::QC_SESSION_BIT]) first_q <= 1'b1;
          end
          rxq_pkg::RECEIVE_DATA_POINTER_OFS: dp_q <= bus.wdata;
          rxq_pkg::DURATION_TIMER_THRESHOLD_OFS: dttr_q <= bus.wdata;
          rxq_pkg::BYTE_COUNT_THRESHOLD_OFS: dbct_q <= bus.wdata;
          rxq_pkg::INTERRUPT_ENABLE_OFS: ier_q <= bus.wdata;
          rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS: fct_q <= bus.wdata[7:0];
          default: ;
        endcase
      end
      if (deq) dp_q[10:0] <= 11'h000;
      if (rd && bus.addr == rxq_pkg::DATA_PORT_OFS && qc_q[rxq_pkg::QC_SESSION_BIT]) begin
        // [RQ17] Dummy unit.
        if (first_q) first_q <= 1'b0;
        // [RQ10] Auto increment.
        else if (dp_q[rxq_pkg::DP_AUTO_INC_BIT]) dp_q[10:0] <= dp_q[10:0] + 11'h002;
      end
      if (rd && bus.addr == rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS) begin
        // [RQ20] Load head header.
        hstat_q <= dstat_q[hs_q];
        hbc_q <= dcnt_q[hs_q];
        hr_q <= hs_q + 5'h01;
        seen_s_q <= 1'b0;
        seen_b_q <= 1'b0;
      end else if (seen_s_q && seen_b_q) begin
        // [RQ21] Step to next header.
        hstat_q <= dstat_q[hr_q];
        hbc_q <= dcnt_q[hr_q];
        hr_q <= hr_q + 5'h01;
        seen_s_q <= 1'b0;
        seen_b_q <= 1'b0;
      end else begin
        if (rd && bus.addr == rxq_pkg::HEAD_FRAME_STATUS_OFS) seen_s_q <= 1'b1;
        if (rd && bus.addr == rxq_pkg::HEAD_FRAME_BYTE_COUNT_OFS) seen_b_q <= 1'b1;
      end
    end
  end

  always_comb begin
    unique case (bus.addr)
      rxq_pkg::RECEIVE_CONTROL_ONE_OFS: rdata_d = rc1_q;
      rxq_pkg::RECEIVE_CONTROL_TWO_OFS: rdata_d = rc2_q;
      // [RQ5] Head status.
      rxq_pkg::HEAD_FRAME_STATUS_OFS: rdata_d = hstat_q;
      // [RQ6] Head byte count.
      rxq_pkg::HEAD_FRAME_BYTE_COUNT_OFS: rdata_d = {4'h0, hbc_q};
      rxq_pkg::QUEUE_CONTROL_OFS: rdata_d = qc_q | {3'h0, ov_q, 10'h000};
      rxq_pkg::RECEIVE_DATA_POINTER_OFS: rdata_d = dp_q;
      rxq_pkg::DURATION_TIMER_THRESHOLD_OFS: rdata_d = dttr_q;
      rxq_pkg::BYTE_COUNT_THRESHOLD_OFS: rdata_d = dbct_q;
      rxq_pkg::INTERRUPT_ENABLE_OFS: rdata_d = ier_q;
      rxq_pkg::INTERRUPT_STATUS_OFS: rdata_d = isr_q;
      rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS: rdata_d = {snap_q, fct_q};
      rxq_pkg::DATA_PORT_OFS: rdata_d = first_q ? 16'h0000 : mem_q[hd_wa];
      default: rdata_d = 16'h0000;
    endcase
  end

  // Every access is answered one cycle after it is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0; rdata_q <= 16'h0000;
    end else begin
      ack_q <= take;
      if (rd) rdata_q <= rdata_d;
    end
  end

  // Pause is raised early so that a frame already arriving still fits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_q <= 1'b0; csum_q <= 4'h0;
    end else begin
      // [RQ3] Flow control request.
      pause_q <= rc1_q[rxq_pkg::RC1_FLOW_BIT] && used_q > 13'(rxq_pkg::PAUSE_WORDS);
      // [RQ4] Checksum enables.
      csum_q <= rc2_q[3:0];
    end
  end

  assign bus.ack   = ack_q;
  assign bus.rdata = rdata_q;
  assign bus.irq   = irq_q;
  assign rx_ready  = rx_ready_q;
  assign rx_pause  = pause_q;
  assign csum_en   = csum_q;
endmodule // rxq_device
`default_nettype wire

// ==== rxq_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxq_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  rxq_if.host              bus,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_got_q, w_got_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic        req_q, we_q;
  logic [7:0]  addr_q;
  logic [15:0] reqd_q, last_q;
  logic        do_wr, cmd_ok, wstrb_all_q;

  assign do_wr  = aw_got_q && w_got_q && !bvalid_q;
  // Partial strobes are refused.
  assign cmd_ok = awaddr_q == rxq_pkg::BR_CMD_OFS && wstrb_all_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0; wready_q <= 1'b0; aw_got_q <= 1'b0; w_got_q <= 1'b0;
      awaddr_q <= 4'h0; wdata_q <= 32'h00000000; wstrb_all_q <= 1'b0;
      bvalid_q <= 1'b0; bresp_q <= rxq_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (!aw_got_q && !bvalid_q) awready_q <= 1'b1;
      if (s_axi_wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_all_q <= &s_axi_wstrb;
        wready_q <= 1'b0;
      end else if (!w_got_q && !bvalid_q) wready_q <= 1'b1;
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (cmd_ok && !req_q) ? rxq_pkg::RESP_OKAY : rxq_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) bvalid_q <= 1'b0;
    end
  end

  // One access at a time, held until ack.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0; we_q <= 1'b0; addr_q <= 8'h00; reqd_q <= 16'h0000; last_q <= 16'h0000;
    end else if (req_q) begin
      if (bus.ack) begin
        req_q <= 1'b0;
        // [RQ17] Dummy data is returned as read; software drops it.
        if (!we_q) last_q <= bus.rdata;
      end
    end else if (do_wr && cmd_ok) begin
      // [RQ7] [RQ16] Relays session and clear writes.
      req_q <= 1'b1;
      addr_q <= wdata_q[7:0];
      we_q <= wdata_q[8];
      reqd_q <= wdata_q[31:16];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0; rvalid_q <= 1'b0; rdata_q <= 32'h00000000; rresp_q <= rxq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rxq_pkg::RESP_OKAY;
      if (s_axi_araddr == rxq_pkg::BR_STATUS_OFS) rdata_q <= {last_q, 14'h0000, bus.irq, req_q};
      else if (s_axi_araddr == rxq_pkg::BR_CMD_OFS) rdata_q <= {reqd_q, 7'h00, we_q, addr_q};
      else begin
        rdata_q <= 32'h00000000;
        rresp_q <= rxq_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q) begin
      if (s_axi_rready) rvalid_q <= 1'b0;
    end else arready_q <= 1'b1;
  end

  assign bus.req       = req_q;
  assign bus.we        = we_q;
  assign bus.addr      = addr_q;
  assign bus.wdata     = reqd_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule // rxq_host
`default_nettype wire

// ==== rxq_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxq_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        irq
);
  logic        ien_q;
  logic        first_q;
  logic [15:0] qc_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd(logic [7:0] a);
    req && !we && ack && addr == a;
  endsequence
  // Shadows of host writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ien_q <= 1'b0;
      qc_q <= 16'h0000;
    end else if (req && we && ack && addr == rxq_pkg::INTERRUPT_ENABLE_OFS) ien_q <= wdata[13];
    else if (req && we && ack && addr == rxq_pkg::QUEUE_CONTROL_OFS) qc_q <= wdata;
  end
  // Only a fresh session start arms the dummy check.
  always_ff @(posedge aclk) begin
    if (!aresetn) first_q <= 1'b0;
    else if (req && we && ack && addr == rxq_pkg::QUEUE_CONTROL_OFS) first_q <= wdata[3] && !qc_q[3];
    else if (req && !we && ack && addr == rxq_pkg::DATA_PORT_OFS) first_q <= 1'b0;
  end
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_timely_a: assert property (req && !ack |=> ack)
    else $error("ack late");
  ack_cause_a: assert property (ack |-> req && $past(req))
    else $error("ack without request");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we))
    else $error("request changed before ack");
  count_width_a: assert property (s_rd(rxq_pkg::HEAD_FRAME_BYTE_COUNT_OFS) |-> rdata[15:12] == 4'h0)
    else $error("byte count above twelve bits");
  frames_max_a: assert property (s_rd(rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS) |-> rdata[15:8] <= rxq_pkg::SLOTS)
    else $error("frame count beyond slots");
  qc_back_a: assert property (s_rd(rxq_pkg::QUEUE_CONTROL_OFS) |-> (rdata & rxq_pkg::QC_WMASK) == (qc_q & rxq_pkg::QC_WMASK))
    else $error("queue control readback wrong");
  irq_gate_a: assert property (!ien_q [*3] |-> !irq)
    else $error("irq while disabled");
  dummy_zero_a: assert property (s_rd(rxq_pkg::DATA_PORT_OFS) ##0 first_q |-> rdata == 16'h0000)
    else $error("dummy read not zero");
endmodule // rxq_sva
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, rx_valid, rx_last, rx_ready, rx_pause;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  rx_data;
  logic [15:0] rx_status, q;
  logic [3:0]  csum_en, awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  int          n_mismatch, checks, seed, k;
  int          eb[2][$];
  always #2.5 aclk = ~aclk;
  rxq_if u_rxq_if (.aclk(aclk));
  rxq_device u_rxq_device (.aclk(aclk), .aresetn(aresetn), .bus(u_rxq_if), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_status(rx_status), .rx_ready(rx_ready),
    .rx_pause(rx_pause), .csum_en(csum_en));
  rxq_host u_rxq_host (.aclk(aclk), .aresetn(aresetn), .bus(u_rxq_if), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  rxq_sva u_rxq_sva (.aclk(aclk), .aresetn(aresetn), .req(u_rxq_if.req), .we(u_rxq_if.we),
    .addr(u_rxq_if.addr), .wdata(u_rxq_if.wdata), .ack(u_rxq_if.ack), .rdata(u_rxq_if.rdata),
    .irq(u_rxq_if.irq));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input logic bad);
    if (bad) begin
      n_mismatch++;
      $display("mismatch wait expected done seen timeout");
      give_verdict();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 400);
    hang(n >= 400);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 400);
    hang(n >= 400);
    r = rresp;
    v = rdata;
    rready <= 1'b0;
  endtask
  // Each access polls until the bridge is idle.
  task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    axi_wr(rxq_pkg::BR_CMD_OFS, {d, 7'h00, w, a}, 4'hf);
    do begin
      axi_rd(rxq_pkg::BR_STATUS_OFS);
      n++;
    end while (v[0] !== 1'b0 && n < 400);
    hang(n >= 400);
    q = v[31:16];
  endtask
  function automatic logic [15:0] hw(input int f, input int i);
    return 16'(eb[f][i] + (eb[f][i + 1] << 8));
  endfunction
  // Expected bytes: status, count, pads as -1 (unchecked), data.
  task automatic send(input int f, input int len, input int pad);
    int i, n;
    logic [15:0] st;
    logic [15:0] cnt;
    st = 16'($random(seed));
    cnt = 16'(len + pad);
    eb[f] = {st[7:0], st[15:8], cnt[7:0], cnt[15:8]};
    repeat (pad) eb[f].push_back(-1);
    for (i = 0; i < len; i++) eb[f].push_back($random(seed) & 255);
    i = 0;
    n = 0;
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_status <= st;
    rx_data <= 8'(eb[f][4 + pad]);
    rx_last <= (len == 1);
    while (i < len && n < 9000) begin
      @(posedge aclk);
      n++;
      if (rx_ready === 1'b1) begin
        i++;
        rx_data <= 8'(eb[f][(4 + pad + i) % eb[f].size()]);
        rx_last <= (i == len - 1);
      end
    end
    hang(n >= 9000);
    rx_valid <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic port(input int f);
    int i;
    dev(1'b1, rxq_pkg::RECEIVE_DATA_POINTER_OFS, 16'h4000);
    dev(1'b1, rxq_pkg::QUEUE_CONTROL_OFS, 16'h0018);
    dev(1'b0, rxq_pkg::DATA_PORT_OFS, 16'h0000);
    chk("dummy", 0, q);
    for (i = 0; i < (eb[f].size() + 3) / 4 * 4; i += 2) begin
      dev(1'b0, rxq_pkg::DATA_PORT_OFS, 16'h0000);
      if (i < eb[f].size() && eb[f][i] >= 0) chk("port_lo", eb[f][i], q[7:0]);
      if (i + 1 < eb[f].size() && eb[f][i + 1] >= 0) chk("port_hi", eb[f][i + 1], q[15:8]);
    end
    dev(1'b1, rxq_pkg::QUEUE_CONTROL_OFS, 16'h0010);
    $display("test port frame %0d done", f);
  endtask
  initial begin
    seed = 45;
    aclk = 1'b0;
    {aresetn, rx_valid, rx_last, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_data, rx_status, awaddr, wdata, wstrb, araddr} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(4'h8);
    chk("rresp", rxq_pkg::RESP_SLVERR, r);
    axi_wr(rxq_pkg::BR_CMD_OFS, 32'h0000_0000, 4'h3);
    chk("bresp", rxq_pkg::RESP_SLVERR, r);
    dev(1'b0, 8'h00, 16'h0000);
    chk("unmapped", 0, q);
    dev(1'b0, rxq_pkg::INTERRUPT_ENABLE_OFS, 16'h0000);
    chk("ier_reset", rxq_pkg::REG_RESET, q);
    k = $random(seed) & 15;
    dev(1'b1, rxq_pkg::RECEIVE_CONTROL_TWO_OFS, 16'(k));
    chk("csum_en", k, csum_en);
    dev(1'b1, rxq_pkg::RECEIVE_CONTROL_ONE_OFS, 16'h0401);
    dev(1'b0, rxq_pkg::RECEIVE_CONTROL_ONE_OFS, 16'h0000);
    chk("rc1", 16'h0401, q);
    chk("pause", 0, rx_pause);
    $display("test registers done");
    send(0, 61 + 2 * ($random(seed) & 15), 0);
    dev(1'b1, rxq_pkg::QUEUE_CONTROL_OFS, 16'h0200);
    send(1, rxq_pkg::FRAME_MAX_BYTES, 2);
    dev(1'b1, rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS, 16'h0000);
    dev(1'b1, rxq_pkg::BYTE_COUNT_THRESHOLD_OFS, 16'h0010);
    dev(1'b1, rxq_pkg::DURATION_TIMER_THRESHOLD_OFS, 16'h0001);
    for (k = 0; k < 3; k++) begin
      dev(1'b1, rxq_pkg::QUEUE_CONTROL_OFS, 16'(1 << (5 + k)));
      repeat (600) @(posedge aclk);
      dev(1'b0, rxq_pkg::QUEUE_CONTROL_OFS, 16'h0000);
      chk("qc_status", 1, q[10 + k]);
    end
    axi_rd(rxq_pkg::BR_STATUS_OFS);
    chk("irq_off", 0, v[1]);
    dev(1'b1, rxq_pkg::INTERRUPT_ENABLE_OFS, 16'h2000);
    axi_rd(rxq_pkg::BR_STATUS_OFS);
    chk("irq_on", 1, v[1]);
    $display("test thresholds done");
    dev(1'b1, rxq_pkg::INTERRUPT_STATUS_OFS, 16'hffff);
    dev(1'b0, rxq_pkg::FRAME_COUNT_AND_THRESHOLD_OFS, 16'h0000);
    chk("frames", 2, q[15:8]);
    for (k = 0; k < 2; k++) begin
      dev(1'b0, rxq_pkg::HEAD_FRAME_STATUS_OFS, 16'h0000);
      chk("head_status", hw(k, 0), q);
      dev(1'b0, rxq_pkg::HEAD_FRAME_BYTE_COUNT_OFS, 16'h0000);
      chk("head_count", hw(k, 2) & 16'h0fff, q[11:0]);
    end
    $display("test headers done");
    port(0);
    port(1);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
